//--- usart_pkg.sv
/*
  Shared constants for the serial transceiver core: register offsets on the
  Wishbone slave, mode and command word fields, status word layout and the
  sequencing states.
  Assumes a single system clock; no other package is needed.
*/
package usart_pkg;

  // Register map, byte addresses on a 4-bit word-aligned address
  localparam int          ADR_W    = 4;
  localparam logic [3:0]  DATA_OFS = 4'h0;
  localparam logic [3:0]  CTRL_OFS = 4'h4;

  // Mode word fields
  localparam int          MODE_BAUD_LSB = 0;
  localparam int          MODE_LEN_LSB  = 2;
  localparam int          MODE_PEN      = 4;
  localparam int          MODE_EVEN     = 5;
  localparam int          MODE_EXTSYNC  = 6;
  localparam int          MODE_SINGLE   = 7;
  localparam int          MODE_STOP2    = 7;
  localparam logic [1:0]  BAUD_SYNC     = 2'h0;
  localparam logic [1:0]  BAUD_X1       = 2'h1;
  localparam logic [1:0]  BAUD_X16      = 2'h2;
  localparam logic [1:0]  BAUD_X64      = 2'h3;
  localparam logic [6:0]  FAC_X1        = 7'h01;
  localparam logic [6:0]  FAC_X16       = 7'h10;
  localparam logic [6:0]  FAC_X64       = 7'h40;
  localparam logic [3:0]  MIN_LEN       = 4'h5;

  // Command word fields
  localparam int          CMD_TXEN   = 0;
  localparam int          CMD_RXEN   = 2;
  localparam int          CMD_BREAK  = 3;
  localparam int          CMD_ERRCLR = 4;
  localparam int          CMD_IRST   = 6;
  localparam int          CMD_HUNT   = 7;

  // Status word fields
  localparam int          ST_TXRDY  = 0;
  localparam int          ST_RX_CHAR_READY  = 1;
  localparam int          ST_TXEMP  = 2;
  localparam int          ST_PERR   = 3;
  localparam int          ST_OVR    = 4;
  localparam int          ST_FERR   = 5;
  localparam int          ST_SYNC_DETECT_PIN = 6;

  // Which control word the next control write loads
  typedef enum logic [1:0] {
    PH_MODE  = 2'b00,
    PH_SYNC1 = 2'b01,
    PH_SYNC2 = 2'b10,
    PH_CMD   = 2'b11
  } phase_t;

  // Asynchronous receiver states
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_BITS  = 2'b10
  } rxst_t;

endpackage

//--- pin_sync.sv
/*
  Three-flop input synchroniser with a glitch filter and edge pulses.
  Assumes the input comes from outside the clk domain; a change is taken
  once the second and third flops agree.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter logic INIT = 1'b0
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Raw input and filtered results
  input  wire logic din,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic rise;
    logic fall;
  } sync_st_t;

  sync_st_t q;
  sync_st_t d;

  // Only the second flop reads the first, so metastability stays contained
  always_comb begin
    d      = q;
    d.s1   = din;
    d.s2   = q.s1;
    d.s3   = q.s2;
    d.rise = 1'b0;
    d.fall = 1'b0;
    if (q.s2 == q.s3 && q.s3 != q.lvl) begin
      d.lvl  = q.s3;
      d.rise = q.s3;
      d.fall = ~q.s3;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '{INIT, INIT, INIT, INIT, 1'b0, 1'b0};
    end else begin
      q <= d;
    end
  end

  assign level = q.lvl;
  assign rise  = q.rise;
  assign fall  = q.fall;

endmodule

//--- usart_mode_command_core.sv
/*
  Programmable serial transceiver core: mode/sync/command word sequencing,
  asynchronous and synchronous transmit and receive, error flags and status.
  Assumes a classic Wishbone master on clk, bit clocks far slower than clk
  (at least about 8 clk periods per bit clock period) and external pins that
  are asynchronous to clk.
*/
`timescale 1ns/1ps
// Functional notes
// - After setup, control writes are commands.
// - Internal reset bit returns to mode format.
// - Parity excluded from length, never read back.
// - Short characters low-aligned, upper bits zero.
// - Async frame: start, data LSB first, parity, stops.
// - Tx on bit clock fall, divided 1/16/64.
// - Start bit rechecked at centre in 16x/64x.
// - Rx samples on rising edge; parity error flag.
// - Only first stop checked; low sets framing.
// - Char loads buffer; unread one overruns.
// - Error clear resets flags; flags never stall.
// - Sync tx idles high until data and clear-to-send.
// - Sync tx fills with sync chars, empty high.
// - Hunt compares every bit; double needs both.
// - Sync detect at last data/parity bit; read clears.
// - Sync parity checked whenever not hunting.
// - Enter hunt fills receive shift register with ones.
// - Outside hunt internal detect only at character boundaries.
// - Status read returns frozen status word.
// - Error clear bit clears parity, overrun, framing.
// - Hunt bit starts search; ignored in async.
module usart_mode_command_core (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // Wishbone slave
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [usart_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  // Serial link
  input  wire logic                      tx_bit_clock,
  input  wire logic                      rx_bit_clock,
  input  wire logic                      serial_in,
  output logic                           serial_out,
  input  wire logic                      cts_n,
  // Sync detect pin, three-signal form
  input  wire logic                      sync_detect_pin_i,
  output logic                           sync_detect_pin_o,
  output logic                           sync_detect_pin_oe_n,
  // Host handshake levels
  output logic                           rx_char_ready,
  output logic                           tx_empty_flag,
  output logic                           tx_ready
);
  import usart_pkg::*;

  // All state; every field resets to zero, so polarities are chosen for that
  typedef struct packed {
    phase_t      phase;
    logic [7:0]  mode;
    logic [7:0]  cmd;
    logic [7:0]  sync1;
    logic [7:0]  sync2;
    logic        ack;
    logic [7:0]  rdata;
    logic [7:0]  txbuf;
    logic        txfull;
    logic [11:0] txsh;
    logic [3:0]  txcnt;
    logic [6:0]  txdiv;
    logic        txlow;
    logic        txstarted;
    logic        txbusy;
    logic        fill2;
    rxst_t       rxst;
    logic [6:0]  rxdiv;
    logic [3:0]  rxcnt;
    logic [7:0]  rxsh;
    logic        rxpar;
    logic [7:0]  rxbuf;
    logic        rdy;
    logic        pe;
    logic        oe;
    logic        fe;
    logic        sync_detect_pin;
    logic        hunt;
    logic [1:0]  hstage;
    logic        prevsync;
    logic        markseen;
  } core_st_t;

  core_st_t q;
  core_st_t d;

  logic txc_fall;
  logic rxc_rise;
  logic rxd_lvl;
  logic cts_lvl;
  logic syn_lvl;

  // Ones in the used character bits
  function automatic logic [7:0] char_mask(input logic [3:0] len);
    char_mask = 8'hff >> (4'd8 - len);
  endfunction

  // Last len bits shifted in, moved down to bit 0
  function automatic logic [7:0] align(input logic [7:0] sh, input logic [3:0] len);
    align = sh >> (4'd8 - len);
  endfunction

  function automatic logic [6:0] factor_of(input logic [1:0] baud);
    case (baud)
      BAUD_X16: factor_of = FAC_X16;
      BAUD_X64: factor_of = FAC_X64;
      default:  factor_of = FAC_X1;
    endcase
  endfunction

  // Parity bit value for a character; even sense gives an even total
  function automatic logic par_of(input logic [7:0] v, input logic even);
    par_of = (^v) ^ ~even;
  endfunction

  // Serial frame, LSB first, padded with ones above the last bit
  function automatic logic [11:0] tx_frame(input logic [7:0] data, input logic [3:0] len,
                                           input logic pen, input logic even,
                                           input logic async_m);
    logic [11:0] w;
    logic [7:0]  dd;
    logic [3:0]  nb;
    dd = data & char_mask(len);
    w  = {4'h0, dd};
    if (pen) begin
      w[len] = par_of(dd, even);
    end
    nb = len + {3'b000, pen};
    if (async_m) begin
      tx_frame = {w[10:0], 1'b0} | (12'hfff << (nb + 4'd1));
    end else begin
      tx_frame = w | (12'hfff << nb);
    end
  endfunction

  // Pin and bit clock synchronisers
  pin_sync #(.INIT(1'b0)) u_txc (
    .clk(clk), .rst(rst), .din(tx_bit_clock), .level(), .rise(), .fall(txc_fall)
  );
  pin_sync #(.INIT(1'b0)) u_rxc (
    .clk(clk), .rst(rst), .din(rx_bit_clock), .level(), .rise(rxc_rise), .fall()
  );
  pin_sync #(.INIT(1'b1)) u_rxd (
    .clk(clk), .rst(rst), .din(serial_in), .level(rxd_lvl), .rise(), .fall()
  );
  pin_sync #(.INIT(1'b1)) u_cts (
    .clk(clk), .rst(rst), .din(cts_n), .level(cts_lvl), .rise(), .fall()
  );
  pin_sync #(.INIT(1'b0)) u_syn (
    .clk(clk), .rst(rst), .din(sync_detect_pin_i), .level(syn_lvl), .rise(), .fall()
  );

  // Next-state logic: transmit, then bus, then receive, then internal reset.
  // Receive runs after the bus so a hardware set beats a same-cycle clear.
  always_comb begin
    logic [3:0]  len;
    logic        pen;
    logic        even;
    logic        sync_m;
    logic        ext;
    logic        single;
    logic [6:0]  fac;
    logic [11:0] fr;
    logic [3:0]  tlen;
    logic        req;
    logic        bnd;
    logic        deliver;
    logic [1:0]  stg;
    logic [7:0]  sh_new;
    logic [7:0]  chv;
    logic        pv;
    logic [7:0]  ch;
    d       = q;
    len     = MIN_LEN + {2'b00, q.mode[MODE_LEN_LSB+:2]};
    pen     = q.mode[MODE_PEN];
    even    = q.mode[MODE_EVEN];
    sync_m  = (q.mode[MODE_BAUD_LSB+:2] == BAUD_SYNC);
    ext     = sync_m & q.mode[MODE_EXTSYNC];
    single  = q.mode[MODE_SINGLE];
    fac     = sync_m ? FAC_X1 : factor_of(q.mode[MODE_BAUD_LSB+:2]);
    fr      = 12'hfff;
    tlen    = len + {3'b000, pen};
    if (!sync_m) begin
      tlen = tlen + 4'd2 + {3'b000, q.mode[MODE_STOP2]};
    end
    req     = wb_cyc_i & wb_stb_i & ~q.ack;
    bnd     = 1'b0;
    deliver = 1'b0;
    stg     = q.hstage;
    sh_new  = {rxd_lvl, q.rxsh[7:1]};
    chv     = 8'h00;
    pv      = 1'b0;
    ch      = q.sync1;

    // Transmit divider and shifter, one bit per divided falling edge
    if (txc_fall) begin
      d.txdiv = (q.txdiv == fac - 7'd1) ? 7'd0 : q.txdiv + 7'd1;
    end
    if (txc_fall && q.txdiv == fac - 7'd1 && q.phase == PH_CMD) begin
      if (q.txcnt != 4'd0) begin
        d.txlow = ~q.txsh[0];
        d.txsh  = {1'b1, q.txsh[11:1]};
        d.txcnt = q.txcnt - 4'd1;
      end else if (q.txfull && q.cmd[CMD_TXEN] && !cts_lvl) begin
        fr          = tx_frame(q.txbuf, len, pen, even, ~sync_m);
        d.txlow     = ~fr[0];
        d.txsh      = {1'b1, fr[11:1]};
        d.txcnt     = tlen - 4'd1;
        d.txfull    = 1'b0;
        d.txstarted = 1'b1;
        d.fill2     = 1'b0;
      end else if (sync_m && q.txstarted) begin
        // Line must keep moving once started, so send sync fill
        ch          = (q.fill2 && !single) ? q.sync2 : q.sync1;
        fr          = tx_frame(ch, len, pen, even, 1'b0);
        d.txlow     = ~fr[0];
        d.txsh      = {1'b1, fr[11:1]};
        d.txcnt     = tlen - 4'd1;
        d.fill2     = ~q.fill2 & ~single;
        d.txbusy    = 1'b0;
      end else begin
        d.txlow  = 1'b0;
        d.txbusy = q.txfull;
      end
    end

    // Wishbone access, answered one cycle after the request edge
    d.ack = req;
    if (req) begin
      d.rdata = 8'h00;
      if (wb_adr_i == DATA_OFS) begin
        if (wb_we_i && wb_sel_i[0]) begin
          d.txbuf  = wb_dat_i[7:0] & char_mask(len);
          d.txfull = 1'b1;
          d.txbusy = 1'b1;
        end else if (!wb_we_i) begin
          d.rdata = q.rxbuf;
          d.rdy   = 1'b0;
        end
      end else if (wb_adr_i == CTRL_OFS) begin
        if (wb_we_i && wb_sel_i[0]) begin
          case (q.phase)
            PH_MODE: begin
              d.mode  = wb_dat_i[7:0];
              d.phase = (wb_dat_i[MODE_BAUD_LSB+:2] == BAUD_SYNC) ? PH_SYNC1 : PH_CMD;
            end
            PH_SYNC1: begin
              d.sync1 = wb_dat_i[7:0] & char_mask(len);
              d.phase = single ? PH_CMD : PH_SYNC2;
            end
            PH_SYNC2: begin
              d.sync2 = wb_dat_i[7:0] & char_mask(len);
              d.phase = PH_CMD;
            end
            default: begin
              d.cmd = wb_dat_i[7:0];
              if (wb_dat_i[CMD_ERRCLR]) begin
                d.pe = 1'b0;
                d.oe = 1'b0;
                d.fe = 1'b0;
              end
              if (wb_dat_i[CMD_HUNT] && sync_m) begin
                d.hunt   = 1'b1;
                d.hstage = 2'd0;
                d.rxcnt  = 4'd0;
                d.rxsh   = 8'hff;
              end
            end
          endcase
        end else if (!wb_we_i) begin
          // Snapshot taken in one cycle, so no update lands mid-read
          d.rdata = {1'b0, q.sync_detect_pin, q.fe, q.oe, q.pe, ~q.txbusy, q.rdy, ~q.txfull};
          d.sync_detect_pin = 1'b0;
        end
      end
    end

    // Receiver, clocked by rising edges of the receive bit clock
    if (rxd_lvl) begin
      d.markseen = 1'b1;
    end
    if (rxc_rise && q.phase == PH_CMD) begin
      if (!sync_m) begin
        case (q.rxst)
          RX_IDLE: begin
            if (q.markseen && !rxd_lvl) begin
              d.rxdiv = (fac == FAC_X1) ? 7'd0 : 7'd1;
              d.rxcnt = 4'd0;
              d.rxst  = (fac == FAC_X1) ? RX_BITS : RX_START;
            end
          end
          RX_START: begin
            if (q.rxdiv == (fac >> 1)) begin
              d.rxdiv = 7'd0;
              d.rxst  = rxd_lvl ? RX_IDLE : RX_BITS;
            end else begin
              d.rxdiv = q.rxdiv + 7'd1;
            end
          end
          RX_BITS: begin
            if (q.rxdiv == fac - 7'd1) begin
              d.rxdiv = 7'd0;
              d.rxcnt = q.rxcnt + 4'd1;
              if (q.rxcnt < len) begin
                d.rxsh = sh_new;
              end else if (pen && q.rxcnt == len) begin
                d.rxpar = rxd_lvl;
              end else begin
                // Only the first stop bit is looked at
                if (!rxd_lvl) begin
                  d.fe = 1'b1;
                end
                d.rxst  = RX_IDLE;
                deliver = 1'b1;
                // Re-arm only once the line is back at mark, so a line held
                // low cannot start another character without a falling edge
                d.markseen = 1'b0;
                chv     = align(q.rxsh, len);
                pv      = q.rxpar;
              end
            end else begin
              d.rxdiv = q.rxdiv + 7'd1;
            end
          end
          default: d.rxst = RX_IDLE;
        endcase
      end else if (ext) begin
        // External detect: pin level may mark any bit boundary
        if (syn_lvl) begin
          d.sync_detect_pin = 1'b1;
        end
        if (q.hunt) begin
          if (syn_lvl) begin
            d.hunt  = 1'b0;
            d.rxcnt = 4'd0;
          end
        end else begin
          bnd = 1'b1;
        end
      end else if (q.hunt && q.hstage == 2'd0) begin
        d.rxsh = sh_new;
        if (align(sh_new, len) == q.sync1) begin
          if (pen) begin
            d.hstage = 2'd1;
            d.rxcnt  = len;
          end else begin
            stg     = 2'd1;
            deliver = 1'b1;
            chv     = q.sync1;
          end
        end
      end else begin
        bnd = 1'b1;
      end
      // Synchronous character assembly, boundary at last data or parity bit
      if (bnd) begin
        if (q.rxcnt < len) begin
          d.rxsh = sh_new;
        end
        if (q.rxcnt == tlen - 4'd1) begin
          d.rxcnt = 4'd0;
          deliver = 1'b1;
          chv     = align((q.rxcnt < len) ? sh_new : q.rxsh, len);
          pv      = (q.rxcnt < len) ? q.rxpar : rxd_lvl;
        end else begin
          d.rxcnt = q.rxcnt + 4'd1;
        end
      end
    end

    // Completed character: hunt progress, or hand over to the host
    if (deliver) begin
      if (sync_m && q.hunt && !ext) begin
        if (stg == 2'd1 && !single) begin
          d.hstage = 2'd2;
          d.rxcnt  = 4'd0;
        end else if (stg == 2'd1 || chv == q.sync2) begin
          d.hunt     = 1'b0;
          d.hstage   = 2'd0;
          d.sync_detect_pin   = 1'b1;
          d.prevsync = 1'b0;
        end else begin
          d.hstage = 2'd0;
        end
      end else begin
        if (pen && pv != par_of(chv, even)) begin
          d.pe = 1'b1;
        end
        if (q.cmd[CMD_RXEN]) begin
          d.rxbuf = chv;
          d.rdy   = 1'b1;
          if (q.rdy) begin
            d.oe = 1'b1;
          end
        end
        if (sync_m && !ext) begin
          d.prevsync = (chv == q.sync1);
          if (single ? (chv == q.sync1) : (q.prevsync && chv == q.sync2)) begin
            d.sync_detect_pin = 1'b1;
          end
        end
      end
    end

    // A disabled receiver holds ready low
    if (!d.cmd[CMD_RXEN]) begin
      d.rdy = 1'b0;
    end

    // Internal reset: back to the mode word, bus answer still completes
    if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == CTRL_OFS && q.phase == PH_CMD
        && wb_dat_i[CMD_IRST]) begin
      d          = '0;
      d.ack      = 1'b1;
      d.markseen = q.markseen;
    end
  end

  // State register; reset value is all zeros
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Outputs
  assign wb_ack_o             = q.ack;
  assign wb_dat_o             = {24'h000000, q.rdata};
  assign serial_out           = ~(q.txlow | q.cmd[CMD_BREAK]);
  assign rx_char_ready        = q.rdy;
  assign tx_empty_flag        = ~q.txbusy;
  assign tx_ready             = ~q.txfull & q.cmd[CMD_TXEN] & ~cts_lvl;
  // Pin driven in all but external sync mode
  assign sync_detect_pin_o    = q.sync_detect_pin;
  assign sync_detect_pin_oe_n = (q.mode[MODE_BAUD_LSB+:2] == BAUD_SYNC) & q.mode[MODE_EXTSYNC];

endmodule

//--- usart_mode_command_core_properties.sv
/*
  Checker for the serial transceiver core: bus timing, read data shape,
  status freezing and reset levels.
  Assumes it is bound to the core and sees only its ports.
*/
`timescale 1ns/1ps
module usart_checker (
  // Clock and reset
  input wire logic                         clk,
  input wire logic                         rst,
  // Wishbone side
  input wire logic                         wb_cyc_i,
  input wire logic                         wb_stb_i,
  input wire logic                         wb_we_i,
  input wire logic [usart_pkg::ADR_W-1:0]  wb_adr_i,
  input wire logic [3:0]                   wb_sel_i,
  input wire logic [31:0]                  wb_dat_o,
  input wire logic                         wb_ack_o,
  // Pins and levels
  input wire logic                         serial_out,
  input wire logic                         sync_detect_pin_o,
  input wire logic                         sync_detect_pin_oe_n,
  input wire logic                         rx_char_ready,
  input wire logic                         tx_empty_flag,
  input wire logic                         tx_ready
);
  import usart_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // A request is taken on an edge where ack is still low
  logic take;
  assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  ack_next_a: assert property (take |=> wb_ack_o)
    else $error("ack did not follow a request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(take))
    else $error("ack without request");
  upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  unmap_zero_a: assert property (take && !wb_we_i && wb_adr_i != DATA_OFS
    && wb_adr_i != CTRL_OFS |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  status_frozen_a: assert property (take && !wb_we_i && wb_adr_i == CTRL_OFS
    |=> wb_dat_o[ST_RX_CHAR_READY] == $past(rx_char_ready)
    && wb_dat_o[ST_TXEMP] == $past(tx_empty_flag) && !wb_dat_o[7])
    else $error("status word does not match levels");
  read_clears_a: assert property (take && !wb_we_i && wb_adr_i == DATA_OFS
    |=> !rx_char_ready)
    else $error("data read left ready high");
  write_fills_a: assert property (take && wb_we_i && wb_sel_i[0]
    && wb_adr_i == DATA_OFS && tx_ready |=> !tx_empty_flag)
    else $error("data write left empty high");
  reset_idle_a: assert property ($fell(rst) |-> serial_out
    && !sync_detect_pin_oe_n && !sync_detect_pin_o)
    else $error("reset levels wrong");

  // Main scenarios reached
  cover property (take && !wb_we_i && wb_adr_i == CTRL_OFS && sync_detect_pin_o);
  cover property ($rose(rx_char_ready));
  cover property ($fell(tx_empty_flag));
endmodule

bind usart_mode_command_core usart_checker u_usart_checker (.clk, .rst, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .serial_out,
  .sync_detect_pin_o, .sync_detect_pin_oe_n, .rx_char_ready, .tx_empty_flag,
  .tx_ready);

//--- serial_peer.sv
/*
  Far-side serial device: sends frames to the core and captures its frames.
  Assumes one free-running bit clock shared by both directions.
*/
`timescale 1ns/1ps
module serial_peer (
  // Link clock
  input  wire logic bit_clock,
  // Lines
  input  wire logic serial_out,
  output logic      serial_in
);
  // Line idles at mark so the core sees it high before a start
  initial serial_in = 1'b1;

  // Bits change on the fall so the core samples them mid-bit on the rise
  task automatic send(input logic [9:0] bits, input int n);
    @(negedge bit_clock);
    serial_in = 1'b0;
    for (int i = 0; i < n; i++) begin
      @(negedge bit_clock);
      serial_in = bits[i];
    end
    @(negedge bit_clock);
    serial_in = 1'b1;
    repeat (2) @(negedge bit_clock);
  endtask

  // Samples at each fall, when the previous bit has long settled
  task automatic grab(input int n, output logic [9:0] bits);
    int k;
    bits = '1;
    for (k = 0; k < 400 && serial_out !== 1'b0; k++) @(negedge bit_clock);
    for (int i = 0; i < n; i++) begin
      @(negedge bit_clock);
      bits[i] = serial_out;
    end
  endtask
endmodule

//--- tb_usart_mode_command_core.sv
/*
  Self-checking bench for the serial transceiver core.
  Assumes the core, its package, the checker and the serial peer model.
*/
`timescale 1ns/1ps
module tb_usart_mode_command_core;
  import usart_pkg::*;
  logic             clk, rst, lclk;
  logic             wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [ADR_W-1:0] wb_adr_i;
  logic [3:0]       wb_sel_i;
  logic [31:0]      wb_dat_i, wb_dat_o;
  logic             serial_in, serial_out, cts_n;
  logic             sync_detect_pin_i, sync_detect_pin_o, sync_detect_pin_oe_n;
  logic             rx_char_ready, tx_empty_flag, tx_ready;
  int               err_count, n_checks;

  usart_mode_command_core u_usart_mode_command_core (.clk, .rst, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .tx_bit_clock(lclk), .rx_bit_clock(lclk), .serial_in, .serial_out, .cts_n,
    .sync_detect_pin_i, .sync_detect_pin_o, .sync_detect_pin_oe_n,
    .rx_char_ready, .tx_empty_flag, .tx_ready);
  serial_peer u_serial_peer (.bit_clock(lclk), .serial_out, .serial_in);

  // System clock 25 MHz; link clock 320 ns, phase unrelated
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #7;
    forever #160 lclk = ~lclk;
  end

  task automatic results();
    if (err_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", name, e, g);
      err_count++;
    end
  endtask

  // One classic cycle; the core answers a cycle after taking it
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_sel_i <= 4'hf;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    // Only the watchdog ends a wait for an answer that never comes
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m,
                    input string name);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(name, e, q & m);
  endtask

  task automatic wait_rx();
    int k;
    for (k = 0; k < 300 && rx_char_ready !== 1'b1; k++) @(posedge clk);
    chk("rx ready", 32'h1, {31'h0, rx_char_ready});
  endtask

  task automatic t_reset();
    @(posedge clk);
    chk("idle levels", 32'h30, {26'h0, serial_out, tx_empty_flag, rx_char_ready,
        sync_detect_pin_oe_n, sync_detect_pin_o, tx_ready});
  endtask

  // Async x1, seven bits, even parity, one stop; then tx enable, rx enable and error clear
  task automatic t_init();
    for (int i = 0; i < 3; i++) wr(CTRL_OFS, 8'h00);
    wr(CTRL_OFS, 8'h40);
    wr(CTRL_OFS, 8'h39);
    wr(CTRL_OFS, 8'h15);
    rd(CTRL_OFS, 32'h05, 32'hff, "status idle");
  endtask

  // Upper bit of the written byte must be dropped
  task automatic t_tx();
    logic [9:0] b;
    chk("tx ready", 32'h1, {31'h0, tx_ready});
    fork
      u_serial_peer.grab(9, b);
      wr(DATA_OFS, 8'hd5);
    join
    chk("tx frame", 32'h155, {23'h0, b[8:0]});
  endtask

  // Good char, then bad parity and stop, then an unread overrun
  task automatic t_rx();
    u_serial_peer.send(10'h1aa, 9);
    wait_rx();
    rd(DATA_OFS, 32'h2a, 32'hffffffff, "rx char");
    u_serial_peer.send(10'h02a, 9);
    u_serial_peer.send(10'h155, 9);
    wait_rx();
    rd(CTRL_OFS, 32'h3a, 32'h3a, "rx errors");
    rd(DATA_OFS, 32'h55, 32'hffffffff, "overwritten char");
    wr(CTRL_OFS, 8'h15);
    rd(CTRL_OFS, 32'h00, 32'h38, "errors cleared");
    wr(CTRL_OFS, 8'h1d);
    chk("break level", 32'h0, {31'h0, serial_out});
    wr(CTRL_OFS, 8'h15);
  endtask

  // Back to mode format, external sync, single sync char, hunt
  task automatic t_sync();
    wr(CTRL_OFS, 8'h40);
    wr(CTRL_OFS, 8'hcc);
    wr(CTRL_OFS, 8'h16);
    chk("pin released", 32'h1, {31'h0, sync_detect_pin_oe_n});
    wr(CTRL_OFS, 8'h84);
    rd(CTRL_OFS, 32'h00, 32'h40, "no sync yet");
    sync_detect_pin_i <= 1'b1;
    repeat (16) @(posedge clk);
    sync_detect_pin_i <= 1'b0;
    repeat (16) @(posedge clk);
    rd(CTRL_OFS, 32'h40, 32'h40, "sync found");
    rd(CTRL_OFS, 32'h00, 32'h40, "sync cleared");
    // Internal detect: hunt finds one 8-bit sync char, no parity
    wr(CTRL_OFS, 8'h40);
    wr(CTRL_OFS, 8'h8c);
    wr(CTRL_OFS, 8'h16);
    wr(CTRL_OFS, 8'h84);
    u_serial_peer.send(10'h016, 8);
    chk("sync pin", 32'h1, {31'h0, sync_detect_pin_o});
    rd(CTRL_OFS, 32'h40, 32'h40, "internal sync");
  endtask

  initial begin
    err_count = 0;
    n_checks = 0;
    rst = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    wb_adr_i = 4'h0;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    cts_n = 1'b0;
    sync_detect_pin_i = 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_init();
    t_tx();
    t_rx();
    rd(4'h8, 32'h0, 32'hffffffff, "unmapped read");
    t_sync();
    results();
  end

  // Whole run is well under a thousand cycles; this only cuts a hang short
  initial begin
    repeat (50000) @(posedge clk);
    err_count++;
    results();
  end
endmodule
